// >>> apm_pkg.sv
// Constants shared by the amplifier protection monitor.
// Assumes a 100 MHz core clock and temperatures coded in whole degrees C.
package apm_pkg;
    // Core clock rate in MHz.
    localparam int CLK_MHZ = 100;
    // Least time a peak short must hold before a channel trips.
    localparam int OVERCURRENT_SHUTDOWN_MIN_US = 200;
    localparam int OVERCURRENT_SHUTDOWN_CYC = OVERCURRENT_SHUTDOWN_MIN_US * CLK_MHZ;
    // One step of the programmed dc-detect hold time.
    localparam int DC_UNIT_US = 10;
    localparam int DC_UNIT_CYC = DC_UNIT_US * CLK_MHZ;
    // Half period of the sync clock driven by the oscillator master.
    localparam int SYNC_HALF_CYC = 125;
    // Width of the time counters.
    localparam int CNT_W = 16;
    // Fixed upper five bits of the 7-bit slave address.
    localparam logic [4:0] DEV_ADDR_HI = 5'h1B;
    // Register offsets.
    localparam logic [7:0] REG_FAULT1 = 8'h00;
    localparam logic [7:0] REG_FAULT2 = 8'h01;
    localparam logic [7:0] REG_STAT1 = 8'h04;
    localparam logic [7:0] REG_HIZ = 8'h05;
    localparam logic [7:0] REG_CTRL2 = 8'h09;
    localparam logic [7:0] REG_CTRL3 = 8'h0A;
    localparam logic [7:0] REG_CTRL5 = 8'h0C;
    localparam logic [7:0] REG_DCPOS = 8'h0E;
    localparam logic [7:0] REG_DCNEG = 8'h0F;
    // Fault register 1 bit positions.
    localparam int F1_OTW = 0;
    localparam int F1_DC = 1;
    localparam int F1_OC = 2;
    localparam int F1_OVERTEMP_SHUTDOWN = 3;
    localparam int F1_UV = 4;
    localparam int F1_OV = 5;
    localparam int F1_LDUMP = 6;
    // Status register 1 bit positions; warnings occupy bits 5 to 7.
    localparam int ST1_UV = 0;
    localparam int ST1_OV = 3;
    localparam int ST1_OVERTEMP_SHUTDOWN = 4;
    localparam int ST1_WARN = 5;
    // Restart-all bit of control register 5.
    localparam int C5_ALL = 7;
    // Reset values.
    localparam logic [7:0] CTRL2_RST = 8'h00;
    localparam logic [7:0] CTRL3_RST = 8'h01;
    localparam logic [7:0] DCLVL_RST = 8'h00;
    // Temperature thresholds in degrees C.
    localparam logic [7:0] TEMP_WARN1 = 8'h7D;
    localparam logic [7:0] TEMP_WARN2 = 8'h87;
    localparam logic [7:0] TEMP_WARN3 = 8'h91;
    localparam logic [7:0] TEMP_HYST = 8'h0A;
    localparam logic [7:0] TEMP_SD_SET = 8'h9B;
    localparam logic [7:0] TEMP_SD_CLR = 8'h91;
    // Sources for the shared clip/warning pin.
    typedef enum logic [1:0] {
        APM_CLIP_ONLY, APM_WARN_ONLY, APM_CLIP_OR_WARN, APM_TWEETER
    } apm_clip_t;
    // Serial port states.
    typedef enum logic [2:0] {
        ST_IDLE, ST_DEV, ST_SUB, ST_WR, ST_RD, ST_ACK, ST_RACK
    } apm_i2c_t;
endpackage

// >>> apm_top.sv
// Protection, monitoring and serial control port of a four-channel amplifier.
// Assumes analog comparators and a temperature sensor feed it asynchronous levels.
`timescale 1ns/10ps
module apm_top #(
    parameter int OVERCURRENT_SHUTDOWN_CYCLES = apm_pkg::OVERCURRENT_SHUTDOWN_CYC
) (
    // Clock and reset.
    input wire logic CLK,
    input wire logic RST_N,
    // Per-channel comparator levels and the single tweeter detect level.
    input wire logic [3:0] AVG_OVER,
    input wire logic [3:0] PEAK_OVER,
    input wire logic [3:0] DC_POS_OVER,
    input wire logic [3:0] DC_NEG_OVER,
    input wire logic [3:0] PWM_FULL,
    input wire logic TWEETER_DET,
    // Supply and temperature monitors.
    input wire logic [2:0] UV_DET,
    input wire logic OV_DET,
    input wire logic LDUMP_DET,
    input wire logic POR_DET,
    input wire logic [7:0] TEMP_C,
    // Address strap and oscillator sync pin.
    input wire logic [1:0] ADDR_SEL,
    input wire logic OSCILLATOR_SYNC_PIN_I,
    output logic OSCILLATOR_SYNC_PIN_O,
    output logic OSCILLATOR_SYNC_PIN_OE_N,
    output logic OSC_MASTER,
    output logic SW_CLK,
    // Serial control port.
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_N,
    // Power stage controls and status pins.
    output logic [3:0] PULSE_CUT,
    output logic [3:0] CH_HIZ,
    output logic [7:0] DC_POS_LEVEL,
    output logic [7:0] DC_NEG_LEVEL,
    output logic FAULT_N,
    output logic CLIP_WARN_N
);
    import apm_pkg::*;

    localparam int SW = 40; // Width of the synchronized input bundle.
    logic [SW-1:0] async_in, sync_m_reg, sync_s_reg;
    logic [3:0] avg_s, peak_s, dcp_s, dcn_s, full_s;
    logic [2:0] uv_s;
    logic ov_s, ld_s, por_s, tw_s, scl_s, sda_s, osc_s;
    logic [7:0] temp_s;
    logic [1:0] sel_s;

    // Every outside level but RST_N passes two flops; the first is read by nothing else.
    // The temperature word must be stable for several cycles at a time.
    assign async_in = {AVG_OVER, PEAK_OVER, DC_POS_OVER, DC_NEG_OVER, PWM_FULL,
                       UV_DET, OV_DET, LDUMP_DET, POR_DET, TWEETER_DET,
                       SCL_I, SDA_I, OSCILLATOR_SYNC_PIN_I, TEMP_C, ADDR_SEL};
    always_ff @(posedge CLK) begin
        sync_m_reg <= async_in;
        sync_s_reg <= sync_m_reg;
    end
    assign {avg_s, peak_s, dcp_s, dcn_s, full_s, uv_s, ov_s, ld_s, por_s,
            tw_s, scl_s, sda_s, osc_s, temp_s, sel_s} = sync_s_reg;

    // Strap is caught once after release of reset.
    logic strap_done_reg;
    logic [1:0] sel_reg;
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            strap_done_reg <= 1'b0;
            sel_reg <= 2'h0;
        end else if (!strap_done_reg) begin
            strap_done_reg <= 1'b1;
            sel_reg <= sel_s;
        end
    end

    // Master divides its own clock onto the sync pin; slaves follow the pin.
    logic [7:0] div_reg;
    logic osc_reg;
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            div_reg <= 8'h00;
            osc_reg <= 1'b0;
            SW_CLK <= 1'b0;
            OSCILLATOR_SYNC_PIN_OE_N <= 1'b1;
            OSC_MASTER <= 1'b0;
        end else begin
            if (div_reg == 8'(SYNC_HALF_CYC - 1)) begin
                div_reg <= 8'h00;
                osc_reg <= ~osc_reg;
            end else begin
                div_reg <= div_reg + 8'h01;
            end
            OSC_MASTER <= strap_done_reg && sel_reg == 2'h0;
            OSCILLATOR_SYNC_PIN_OE_N <= !(strap_done_reg && sel_reg == 2'h0);
            SW_CLK <= (sel_reg == 2'h0) ? osc_reg : osc_s;
        end
    end
    assign OSCILLATOR_SYNC_PIN_O = osc_reg;

    // Serial edge detection on the synchronized copies.
    logic scl_d_reg, sda_d_reg;
    always_ff @(posedge CLK) begin
        scl_d_reg <= scl_s;
        sda_d_reg <= sda_s;
    end
    logic scl_rise, scl_fall, bus_start, bus_stop;
    assign scl_rise = scl_s && !scl_d_reg;
    assign scl_fall = !scl_s && scl_d_reg;
    assign bus_start = scl_s && scl_d_reg && sda_d_reg && !sda_s;
    assign bus_stop = scl_s && scl_d_reg && !sda_d_reg && sda_s;

    apm_i2c_t state_reg, after_reg;
    logic [2:0] bit_reg;
    logic [7:0] shift_reg, sub_reg, wr_addr_reg, wr_data_reg, rd_byte;
    logic byte_rdy_reg, wr_stb_reg, rw_reg;
    logic [6:0] dev_addr;
    assign dev_addr = {DEV_ADDR_HI, sel_reg};

    // Slave engine; SCL is never held, so no stretching can occur.
    // A power-on reset drops the engine and floats the data line.
    always_ff @(posedge CLK) begin
        wr_stb_reg <= 1'b0;
        if (!RST_N || por_s) begin
            state_reg <= ST_IDLE;
            after_reg <= ST_IDLE;
            bit_reg <= 3'h0;
            shift_reg <= 8'h00;
            sub_reg <= 8'h00;
            byte_rdy_reg <= 1'b0;
            rw_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            wr_data_reg <= 8'h00;
            SDA_OE_N <= 1'b1;
        end else if (bus_start) begin
            state_reg <= ST_DEV;
            bit_reg <= 3'h0;
            byte_rdy_reg <= 1'b0;
            SDA_OE_N <= 1'b1;
        end else if (bus_stop) begin
            state_reg <= ST_IDLE;
            SDA_OE_N <= 1'b1;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    SDA_OE_N <= 1'b1;
                end
                ST_DEV, ST_SUB, ST_WR: begin
                    if (scl_rise) begin
                        shift_reg <= {shift_reg[6:0], sda_s};
                        bit_reg <= bit_reg + 3'h1;
                        byte_rdy_reg <= (bit_reg == 3'h7);
                    end else if (scl_fall && byte_rdy_reg) begin
                        byte_rdy_reg <= 1'b0;
                        state_reg <= ST_ACK;
                        SDA_OE_N <= 1'b0;
                        if (state_reg == ST_DEV) begin
                            rw_reg <= shift_reg[0];
                            after_reg <= shift_reg[0] ? ST_RD : ST_SUB;
                            if (shift_reg[7:1] != dev_addr) begin
                                state_reg <= ST_IDLE;
                                SDA_OE_N <= 1'b1;
                            end
                        end else if (state_reg == ST_SUB) begin
                            sub_reg <= shift_reg;
                            after_reg <= ST_WR;
                        end else begin
                            wr_stb_reg <= 1'b1;
                            wr_addr_reg <= sub_reg;
                            wr_data_reg <= shift_reg;
                            sub_reg <= sub_reg + 8'h01;
                        end
                    end
                end
                ST_ACK: begin
                    // Acknowledge held for the whole ninth clock.
                    if (scl_fall) begin
                        bit_reg <= 3'h0;
                        state_reg <= after_reg;
                        shift_reg <= rd_byte;
                        SDA_OE_N <= (after_reg == ST_RD) ? rd_byte[7] : 1'b1;
                    end
                end
                ST_RD: begin
                    if (scl_fall) begin
                        if (bit_reg == 3'h7) begin
                            SDA_OE_N <= 1'b1;
                            state_reg <= ST_RACK;
                            sub_reg <= sub_reg + 8'h01;
                        end else begin
                            SDA_OE_N <= shift_reg[6];
                            shift_reg <= {shift_reg[6:0], 1'b0};
                            bit_reg <= bit_reg + 3'h1;
                        end
                    end
                end
                ST_RACK: begin
                    // A not-acknowledge ends the read; stop follows.
                    if (scl_rise) begin
                        state_reg <= sda_s ? ST_IDLE : ST_ACK;
                    end
                end
            endcase
        end
    end
    assign SDA_O = 1'b0;

    // Configuration returns to reset on power-on reset or load dump.
    logic [7:0] ctrl2_reg, ctrl3_reg;
    logic cfg_rst;
    assign cfg_rst = !RST_N || por_s || ld_s;
    always_ff @(posedge CLK) begin
        if (cfg_rst) begin
            ctrl2_reg <= CTRL2_RST;
            ctrl3_reg <= CTRL3_RST;
            DC_POS_LEVEL <= DCLVL_RST;
            DC_NEG_LEVEL <= DCLVL_RST;
        end else if (wr_stb_reg) begin
            if (wr_addr_reg == REG_CTRL2) ctrl2_reg <= wr_data_reg;
            if (wr_addr_reg == REG_CTRL3) ctrl3_reg <= wr_data_reg;
            if (wr_addr_reg == REG_DCPOS) DC_POS_LEVEL <= wr_data_reg;
            if (wr_addr_reg == REG_DCNEG) DC_NEG_LEVEL <= wr_data_reg;
        end
    end

    // Restart strobes from control register 5.
    logic [3:0] rst_ch;
    logic rst_all;
    assign rst_all = wr_stb_reg && wr_addr_reg == REG_CTRL5 && wr_data_reg[C5_ALL];
    assign rst_ch = (wr_stb_reg && wr_addr_reg == REG_CTRL5) ? wr_data_reg[3:0] : 4'h0;

    // Per-channel trip timers: peak short and held dc offset.
    logic [3:0] oc_trip, dc_trip, off_reg;
    logic [CNT_W-1:0] dc_lim;
    assign dc_lim = CNT_W'((ctrl2_reg[7:4] + 5'h01) * DC_UNIT_CYC);
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_ch
            logic [CNT_W-1:0] oc_cnt_reg, dc_cnt_reg;
            // Counts while the peak short holds; releases reset the count.
            always_ff @(posedge CLK) begin
                if (!RST_N || !peak_s[g] || off_reg[g]) begin
                    oc_cnt_reg <= '0;
                end else if (!oc_trip[g]) begin
                    oc_cnt_reg <= oc_cnt_reg + 1'b1;
                end
            end
            assign oc_trip[g] = peak_s[g] && !off_reg[g]
                && oc_cnt_reg == CNT_W'(OVERCURRENT_SHUTDOWN_CYCLES - 1);
            // Either polarity over its threshold keeps the dc count running.
            always_ff @(posedge CLK) begin
                if (!RST_N || !(dcp_s[g] || dcn_s[g]) || off_reg[g]) begin
                    dc_cnt_reg <= '0;
                end else if (!dc_trip[g]) begin
                    dc_cnt_reg <= dc_cnt_reg + 1'b1;
                end
            end
            assign dc_trip[g] = (dcp_s[g] || dcn_s[g]) && !off_reg[g]
                && dc_cnt_reg == dc_lim - 1'b1;
        end
    endgenerate

    // Temperature levels with hysteresis and shutdown.
    logic [2:0] warn_reg;
    logic overtemp_shutdown_reg;
    logic [7:0] warn_th [3];
    assign warn_th = '{TEMP_WARN1, TEMP_WARN2, TEMP_WARN3};
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            warn_reg <= 3'h0;
            overtemp_shutdown_reg <= 1'b0;
        end else begin
            for (int k = 0; k < 3; k++) begin
                if (temp_s >= warn_th[k]) warn_reg[k] <= 1'b1;
                else if (temp_s < warn_th[k] - TEMP_HYST) warn_reg[k] <= 1'b0;
            end
            if (temp_s >= TEMP_SD_SET) overtemp_shutdown_reg <= 1'b1;
            else if (temp_s <= TEMP_SD_CLR) overtemp_shutdown_reg <= 1'b0;
        end
    end

    // Channel shutdown; a trip in the cycle of a restart wins.
    logic gsd_reg;
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            off_reg <= 4'h0;
            gsd_reg <= 1'b0;
        end else begin
            off_reg <= (off_reg & ~(rst_ch | {4{rst_all}}))
                | oc_trip | (dc_trip & ctrl2_reg[3:0]);
            gsd_reg <= overtemp_shutdown_reg || ld_s || (gsd_reg && !rst_all);
        end
    end

    // Latched fault registers and an unlatched status register; set wins over clear.
    logic [7:0] fault1_reg, fault2_reg, stat1_reg, f1_set;
    assign f1_set = {1'b0, ld_s, ov_s, |uv_s, overtemp_shutdown_reg, |oc_trip, |dc_trip, warn_reg[0]};
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            fault1_reg <= 8'h00;
            fault2_reg <= 8'h00;
            stat1_reg <= 8'h00;
        end else begin
            fault1_reg <= (fault1_reg & ~{8{rst_all}}) | f1_set;
            // A channel restart clears both its overcurrent and its dc bits.
            fault2_reg <= (fault2_reg & ~{2{rst_ch}} & ~{8{rst_all}})
                | {oc_trip, dc_trip};
            stat1_reg <= {warn_reg, overtemp_shutdown_reg, ov_s, uv_s};
        end
    end

    // Read data for the current subaddress.
    always_comb begin
        unique case (sub_reg)
            REG_FAULT1: rd_byte = fault1_reg;
            REG_FAULT2: rd_byte = fault2_reg;
            REG_STAT1: rd_byte = stat1_reg;
            REG_HIZ: rd_byte = {4'h0, CH_HIZ};
            REG_CTRL2: rd_byte = ctrl2_reg;
            REG_CTRL3: rd_byte = ctrl3_reg;
            REG_DCPOS: rd_byte = DC_POS_LEVEL;
            REG_DCNEG: rd_byte = DC_NEG_LEVEL;
            default: rd_byte = 8'h00;
        endcase
    end

    // Output stage drive, fault pin and shared clip/warning pin.
    logic clip_on, tw_on;
    apm_clip_t mode;
    assign mode = apm_clip_t'(ctrl3_reg[1:0]);
    assign clip_on = |(full_s & ~CH_HIZ);
    always_comb begin
        unique case (mode)
            APM_CLIP_ONLY: tw_on = clip_on;
            APM_WARN_ONLY: tw_on = warn_reg[0];
            APM_CLIP_OR_WARN: tw_on = clip_on || warn_reg[0];
            APM_TWEETER: tw_on = tw_s;
        endcase
    end
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            CH_HIZ <= 4'hF;
            PULSE_CUT <= 4'h0;
            FAULT_N <= 1'b1;
            CLIP_WARN_N <= 1'b1;
        end else begin
            CH_HIZ <= off_reg | {4{gsd_reg || |uv_s}};
            PULSE_CUT <= avg_s & ~CH_HIZ;
            FAULT_N <= !(|off_reg || gsd_reg || |uv_s || ov_s);
            CLIP_WARN_N <= !tw_on;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    property p_cut; avg_s[0] && !CH_HIZ[0] && !peak_s[0]
        |=> PULSE_CUT[0] && !oc_trip[0]; endproperty
    a_cut: assert property (p_cut) else $error("pulse cut missing");
    property p_oc; oc_trip[2] |=> off_reg[2] ##1 CH_HIZ[2] && !FAULT_N; endproperty
    a_oc: assert property (p_oc) else $error("overcurrent trip lost");
    property p_flt; oc_trip[2] |=> fault2_reg[6] && fault1_reg[F1_OC]; endproperty
    a_flt: assert property (p_flt) else $error("fault not recorded");
    property p_dc; dc_trip[2] && ctrl2_reg[2] |=> off_reg[2] ##1 !FAULT_N; endproperty
    a_dc: assert property (p_dc) else $error("dc shutdown lost");
    property p_dcoff; dc_trip[0] && !ctrl2_reg[0] && !off_reg[0] && !oc_trip[0]
        |=> !off_reg[0]; endproperty
    a_dcoff: assert property (p_dcoff) else $error("dc trip shut channel");
    property p_clip; mode == APM_CLIP_ONLY && clip_on |=> !CLIP_WARN_N; endproperty
    a_clip: assert property (p_clip) else $error("clip not shown");
    property p_warn; mode == APM_WARN_ONLY && $rose(warn_reg[0]) |=> !CLIP_WARN_N; endproperty
    a_warn: assert property (p_warn) else $error("warning not shown");
    property p_overtemp_shutdown; overtemp_shutdown_reg |=> ##1 CH_HIZ == 4'hF && !FAULT_N; endproperty
    a_overtemp_shutdown: assert property (p_overtemp_shutdown) else $error("overtemp outputs not Hi-Z");
    property p_uv; uv_s[1] |=> stat1_reg[ST1_UV + 1] && !FAULT_N; endproperty
    a_uv: assert property (p_uv) else $error("undervoltage not flagged");
    property p_por; por_s |=> SDA_OE_N && state_reg == ST_IDLE; endproperty
    a_por: assert property (p_por) else $error("port not floated on reset");
    property p_ack; state_reg == ST_ACK && !rw_reg |-> !SDA_OE_N; endproperty
    a_ack: assert property (p_ack) else $error("acknowledge released");
    c_oc: cover property (off_reg[2] && rst_ch[2]);
    c_rd: cover property (state_reg == ST_RD ##[1:1000] state_reg == ST_RACK);
    c_wr: cover property (wr_stb_reg && wr_addr_reg == REG_CTRL3);
endmodule // apm_top

// >>> apm_i2c_master.sv
// Serial bus master model that faces the control port of the protection block.
// Assumes the bench resolves SDA as a wired-AND line with a pull-up.
`timescale 1ns/10ps
module apm_i2c_master (
    // Bus lines; sda_rel high lets the pull-up win.
    output logic scl,
    output logic sda_rel,
    input wire logic sda
);
    // Quarter bit time; four of them make one 125 ns clock period.
    localparam real Q = 31.25;
    // The bus idles released.
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    // Start or repeated start: data falls while the clock is high.
    task automatic start;
        sda_rel = 1'b1;
        #Q scl = 1'b1;
        #Q sda_rel = 1'b0;
        #Q scl = 1'b0;
        #Q;
    endtask
    // Stop: data rises while the clock is high, so the bus ends released.
    task automatic stop;
        sda_rel = 1'b0;
        #Q scl = 1'b1;
        #Q sda_rel = 1'b1;
        #Q;
    endtask
    // One clock pulse; data moves only in the low time, never near the rise.
    task automatic bit_io(input logic b, output logic r);
        sda_rel = b;
        #Q scl = 1'b1;
        #Q r = sda;
        #Q scl = 1'b0;
        #Q;
    endtask
    // Byte out, most significant bit first, then the acknowledge clock.
    task automatic wb(input logic [7:0] b, output logic ack);
        logic d;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], d);
        end
        bit_io(1'b1, ack);
    endtask
    // Byte in, most significant bit first; nack high ends a read.
    task automatic rb(input logic nack, output logic [7:0] b);
        logic d;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, b[i]);
        end
        bit_io(nack, d);
    endtask
endmodule // apm_i2c_master

// >>> tb.sv
// Self-checking bench for the amplifier protection monitor.
// Assumes the master model above and a strap of zero (oscillator master).
`timescale 1ns/10ps
module tb;
    import apm_pkg::*;
    logic CLK = 0, RST_N = 0, ov = 0, tw = 0, ld = 0, por = 0, sync_i = 0;
    logic [3:0] avg = 0, peak = 0, dcp = 0, dcn = 0, full = 0;
    logic [2:0] uv = 0;
    logic [7:0] temp = 8'h19, rdat;
    logic [1:0] asel = 0;
    logic a0, a1, a2, a3;
    wire scl, sda_rel, sda_o, sda_oe_n, fault_n, warn_n, osc_m, sync_oe_n, sw_clk;
    wire [3:0] cut, hiz;
    wire [7:0] dpos, dneg;
    // Wired-AND data line with pull-up.
    wire sda = sda_rel & (sda_oe_n | sda_o);
    int fail_count = 0, checked = 0;
    apm_top #(.OVERCURRENT_SHUTDOWN_CYCLES(50)) apm_top_inst (.CLK(CLK), .RST_N(RST_N), .AVG_OVER(avg),
        .PEAK_OVER(peak), .DC_POS_OVER(dcp), .DC_NEG_OVER(dcn), .PWM_FULL(full),
        .TWEETER_DET(tw), .UV_DET(uv), .OV_DET(ov), .LDUMP_DET(ld), .POR_DET(por),
        .TEMP_C(temp), .ADDR_SEL(asel), .OSCILLATOR_SYNC_PIN_I(sync_i), .OSCILLATOR_SYNC_PIN_O(),
        .OSCILLATOR_SYNC_PIN_OE_N(sync_oe_n), .OSC_MASTER(osc_m), .SW_CLK(sw_clk), .SCL_I(scl),
        .SDA_I(sda),
        .SDA_O(sda_o), .SDA_OE_N(sda_oe_n), .PULSE_CUT(cut), .CH_HIZ(hiz),
        .DC_POS_LEVEL(dpos), .DC_NEG_LEVEL(dneg), .FAULT_N(fault_n), .CLIP_WARN_N(warn_n));
    apm_i2c_master apm_i2c_master_inst (.scl(scl), .sda_rel(sda_rel), .sda(sda));
    initial forever #5 CLK = ~CLK;
    // Single compare for every result, padded to a byte.
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic conclude;
        if (fail_count == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Two sync flops plus a register stage, with margin.
    task automatic settle;
        repeat (8) @(negedge CLK);
    endtask
    // The 1 ns offset keeps bus edges clear of both clock edges.
    task automatic wr(input logic [7:0] sub, input logic [7:0] d);
        @(negedge CLK) #1;
        apm_i2c_master_inst.start;
        apm_i2c_master_inst.wb(8'hD8, a0);
        apm_i2c_master_inst.wb(sub, a1);
        apm_i2c_master_inst.wb(d, a2);
        apm_i2c_master_inst.stop;
        chk("write ack", 8'h00, {5'h00, a0, a1, a2});
        settle;
    endtask
    task automatic rd(input logic [7:0] sub, input logic [7:0] e);
        @(negedge CLK) #1;
        apm_i2c_master_inst.start;
        apm_i2c_master_inst.wb(8'hD8, a0);
        apm_i2c_master_inst.wb(sub, a1);
        apm_i2c_master_inst.start;
        apm_i2c_master_inst.wb(8'hD9, a2);
        apm_i2c_master_inst.rb(1'b1, rdat);
        apm_i2c_master_inst.stop;
        chk("read ack", 8'h00, {5'h00, a0, a1, a2});
        chk("read data", e, rdat);
        settle;
    endtask
    // Reset levels, strap role, clip pin default and a foreign address.
    task automatic t_reset;
        chk("pins", 8'h07, {4'h0, sync_oe_n, fault_n, warn_n, osc_m});
        // The master's switching clock flips once every half period.
        rdat = {7'h00, sw_clk};
        repeat (SYNC_HALF_CYC) @(negedge CLK);
        chk("sw clk", {7'h00, !rdat[0]}, {7'h00, sw_clk});
        rd(REG_CTRL3, CTRL3_RST);
        @(negedge CLK) #1;
        apm_i2c_master_inst.start;
        apm_i2c_master_inst.wb(8'hDA, a0);
        apm_i2c_master_inst.stop;
        chk("foreign nack", 8'h01, {7'h00, a0});
        wr(REG_CTRL5, 8'h8F);
        chk("restart", 8'h00, {4'h0, hiz});
    endtask
    // Two thresholds in one transfer, subaddress auto-incremented.
    task automatic t_dc_levels;
        @(negedge CLK) #1;
        apm_i2c_master_inst.start;
        apm_i2c_master_inst.wb(8'hD8, a0);
        apm_i2c_master_inst.wb(REG_DCPOS, a1);
        apm_i2c_master_inst.wb(8'h5A, a2);
        apm_i2c_master_inst.wb(8'hA5, a3);
        apm_i2c_master_inst.stop;
        settle;
        chk("seq ack", 8'h00, {4'h0, a0, a1, a2, a3});
        chk("dc pos", 8'h5A, dpos);
        chk("dc neg", 8'hA5, dneg);
    endtask
    // Average overload only cuts pulses; a held peak trips one channel.
    task automatic t_current;
        avg = 4'h5;
        settle;
        chk("cut", 8'h05, {4'h0, cut});
        chk("cbc play", 8'h01, {3'h0, hiz, fault_n});
        avg = 4'h0;
        peak = 4'h4;
        repeat (20) @(negedge CLK);
        chk("early", 8'h00, {4'h0, hiz});
        repeat (50) @(negedge CLK);
        chk("trip", 8'h08, {3'h0, hiz, fault_n});
        peak = 4'h0;
        settle;
        rd(REG_FAULT2, 8'h40);
        wr(REG_CTRL5, 8'h04);
        chk("ch restart", 8'h00, {4'h0, hiz});
        rd(REG_FAULT2, 8'h00);
    endtask
    // Held offsets: channel 2 enabled for shutdown, channel 0 only reports.
    task automatic t_dc;
        wr(REG_CTRL2, 8'h04);
        dcp = 4'h4;
        dcn = 4'h1;
        repeat (900) @(negedge CLK);
        chk("dc early", 8'h01, {3'h0, hiz, fault_n});
        repeat (200) @(negedge CLK);
        chk("dc trip", 8'h08, {3'h0, hiz, fault_n});
        dcp = 4'h0;
        dcn = 4'h0;
        rd(REG_FAULT2, 8'h05);
        wr(REG_CTRL5, 8'h05);
        rd(REG_FAULT2, 8'h00);
    endtask
    // Warning levels, shutdown and both hysteresis points.
    task automatic t_temp;
        temp = TEMP_WARN1;
        settle;
        chk("warn pin", 8'h00, {7'h00, warn_n});
        rd(REG_STAT1, 8'h20);
        temp = TEMP_SD_SET;
        settle;
        chk("overtemp_shutdown", 8'h1E, {3'h0, hiz, fault_n});
        rd(REG_STAT1, 8'hF0);
        temp = TEMP_SD_CLR;
        settle;
        wr(REG_CTRL5, 8'h8F);
        chk("overtemp_shutdown clear", 8'h00, {4'h0, hiz});
        temp = 8'h73;
        settle;
        chk("warn held", 8'h00, {7'h00, warn_n});
        temp = 8'h72;
        settle;
        chk("warn off", 8'h01, {7'h00, warn_n});
    endtask
    // Every pin source against a full-duty channel and a tweeter hit.
    task automatic t_clip_modes;
        for (int k = 0; k < 4; k++) begin
            wr(REG_CTRL3, 8'(k));
            full = 4'h8;
            settle;
            chk("clip", {7'h00, !(k == 0 || k == 2)}, {7'h00, warn_n});
            full = 4'h0;
            tw = 1'b1;
            settle;
            chk("tweeter", {7'h00, k != 3}, {7'h00, warn_n});
            tw = 1'b0;
        end
    endtask
    // Analog undervoltage, then overvoltage, each with its status bit.
    task automatic t_supply;
        uv = 3'h2;
        settle;
        chk("uv", 8'h1E, {3'h0, hiz, fault_n});
        rd(REG_STAT1, 8'h02);
        uv = 3'h0;
        ov = 1'b1;
        settle;
        chk("ov", 8'h00, {7'h00, fault_n});
        rd(REG_STAT1, 8'h08);
        ov = 1'b0;
        settle;
        chk("ok", 8'h01, {7'h00, fault_n});
        por = 1'b1;
        settle;
        por = 1'b0;
        rd(REG_CTRL3, CTRL3_RST);
        ld = 1'b1;
        settle;
        chk("ldump", 8'h1E, {3'h0, hiz, fault_n});
        ld = 1'b0;
        wr(REG_CTRL5, 8'h80);
        chk("ld restart", 8'h01, {3'h0, hiz, fault_n});
        rd(REG_DCPOS, DCLVL_RST);
    endtask
    // A hang counts as a mismatch.
    initial begin
        #500us;
        fail_count++;
        conclude;
    end
    initial begin
        repeat (6) @(negedge CLK);
        chk("hiz", 8'h0F, {4'h0, hiz});
        RST_N = 1'b1;
        repeat (4) @(negedge CLK);
        t_reset;
        t_dc_levels;
        t_current;
        t_dc;
        t_temp;
        t_clip_modes;
        t_supply;
        conclude;
    end
endmodule // tb
